// ### urs_consts.svh
`ifndef URS_CONSTS_SVH
`define URS_CONSTS_SVH
// special-function address of the endpoint-indexed receive status register
`define URS_ADDR_RXSTATUS 8'he2
`define URS_RESET_STATUS 8'h00
// field positions inside the status byte
`define URS_BIT_ACK 0
`define URS_BIT_ERR 1
`define URS_BIT_VOID 2
`define URS_BIT_TOGGLE_OVW 3
`define URS_BIT_END_OVW 4
`define URS_BIT_START_OVW 5
`define URS_BIT_SETUP 6
`define URS_BIT_TOGGLE 7
`endif

// ### urs_pkg.sv
package urs_pkg;
  // outcome of one receive data phase
  typedef enum logic [1:0] {
    URS_RES_NONE,
    URS_RES_ACK,
    URS_RES_ERR,
    URS_RES_VOID
  } urs_result_t;
endpackage : urs_pkg

// ### urs_receive_status.sv
`timescale 1ns/100ps
`include "urs_consts.svh"
module urs_receive_status #(
  parameter int NumEp = 4,
  parameter int IdxW = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // transaction end from the serial interface engine
  input wire logic rxDone,
  input wire logic [IdxW-1:0] rxEp,
  input wire logic rxIso,
  input wire logic rxIsSetup,
  input wire logic rxValidToken,
  input wire logic crcFail,
  input wire logic stuffError,
  input wire logic fifoOverUnder,
  input wire logic fifoLocked,
  input wire logic [NumEp-1:0] receiveStallControl,
  input wire logic sofSeen,
  // data toggle tracking
  input wire logic rxToggleIn,
  // firmware special-function access
  input wire logic [IdxW-1:0] epIndex,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic [7:0] sfrWdata,
  input wire logic [NumEp-1:0] doneClear,
  // results
  output logic [7:0] sfrRdata,
  output logic rxHandshakeAck,
  output logic [NumEp-1:0] endpointReceiveDoneBit
);
  // ==========================================================
  // receive outcome classification
  urs_pkg::urs_result_t res;
  logic voidCond;
  always_comb begin
    voidCond = fifoLocked || receiveStallControl[rxEp];
    if (voidCond) begin
      res = urs_pkg::URS_RES_VOID;
    end else if (crcFail || stuffError || fifoOverUnder) begin
      res = urs_pkg::URS_RES_ERR;
    end else begin
      res = urs_pkg::URS_RES_ACK;
    end
  end

  // ==========================================================
  // per-endpoint status, pending iso results
  logic [NumEp-1:0] ack_q, err_q, void_q, toggle_q;
  logic [NumEp-1:0] pend_q;
  urs_pkg::urs_result_t pendRes_q [NumEp];
  logic wrStatus;
  assign wrStatus = sfrWr && (sfrAddr == `URS_ADDR_RXSTATUS);

  genvar g;
  generate
    for (g = 0; g < NumEp; g++) begin : gEp
      logic hit;
      logic apply;
      urs_pkg::urs_result_t applyRes;
      assign hit = rxDone && rxValidToken && (rxEp == IdxW'(g));
      // non-iso applies at end, iso waits for sof
      assign apply = (hit && !rxIso) || (pend_q[g] && sofSeen);
      assign applyRes = (hit && !rxIso) ? res : pendRes_q[g];
      always_ff @(posedge clock) begin
        if (!nrst) begin
          pend_q[g] <= 1'b0;
          pendRes_q[g] <= urs_pkg::URS_RES_NONE;
        end else if (hit && rxIso) begin
          pend_q[g] <= 1'b1;
          pendRes_q[g] <= res;
        end else if (sofSeen) begin
          pend_q[g] <= 1'b0;
        end
      end
      always_ff @(posedge clock) begin
        if (!nrst) begin
          ack_q[g] <= 1'b0;
          err_q[g] <= 1'b0;
          void_q[g] <= 1'b0;
        end else if (apply) begin
          // all three flags written together, never two set
          ack_q[g] <= (applyRes == urs_pkg::URS_RES_ACK);
          err_q[g] <= (applyRes == urs_pkg::URS_RES_ERR);
          void_q[g] <= (applyRes == urs_pkg::URS_RES_VOID);
        end
      end
      always_ff @(posedge clock) begin
        if (!nrst) begin
          endpointReceiveDoneBit[g] <= 1'b0;
        end else if (apply && (applyRes == urs_pkg::URS_RES_ACK
                               || applyRes == urs_pkg::URS_RES_ERR)) begin
          endpointReceiveDoneBit[g] <= 1'b1;
        end else if (doneClear[g]) begin
          endpointReceiveDoneBit[g] <= 1'b0;
        end
      end
      always_ff @(posedge clock) begin
        if (!nrst) begin
          toggle_q[g] <= 1'b0;
        end else if (wrStatus && epIndex == IdxW'(g)
                     && sfrWdata[`URS_BIT_TOGGLE_OVW]) begin
          toggle_q[g] <= sfrWdata[`URS_BIT_TOGGLE];
        end else if (apply && applyRes == urs_pkg::URS_RES_ACK) begin
          toggle_q[g] <= ~toggle_q[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // handshake: ack only for complete reception, none on error
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rxHandshakeAck <= 1'b0;
    end else begin
      rxHandshakeAck <= rxDone && rxValidToken && (res == urs_pkg::URS_RES_ACK);
    end
  end

  // ==========================================================
  // indexed read port
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sfrRdata <= `URS_RESET_STATUS;
    end else begin
      sfrRdata <= `URS_RESET_STATUS;
      if (sfrAddr == `URS_ADDR_RXSTATUS) begin
        sfrRdata[`URS_BIT_ACK] <= ack_q[epIndex];
        sfrRdata[`URS_BIT_ERR] <= err_q[epIndex];
        sfrRdata[`URS_BIT_VOID] <= void_q[epIndex];
        sfrRdata[`URS_BIT_TOGGLE] <= toggle_q[epIndex];
      end
    end
  end

  // ==========================================================
  // checks
  flags_exclusive_a: assert property (@(posedge clock) disable iff (!nrst)
    (ack_q & err_q) == '0) else $error("ack and error both set");
  ack_handshake_a: assert property (@(posedge clock) disable iff (!nrst)
    rxDone && rxValidToken && !voidCond && (crcFail || stuffError || fifoOverUnder)
    |=> !rxHandshakeAck) else $error("handshake after error");
  void_stall_a: assert property (@(posedge clock) disable iff (!nrst)
    rxDone && rxValidToken && !rxIso && receiveStallControl[rxEp]
    |=> void_q[$past(rxEp)]) else $error("void missing");
  iso_defer_a: assert property (@(posedge clock) disable iff (!nrst)
    rxDone && rxValidToken && rxIso && !sofSeen |=> $stable(ack_q))
    else $error("iso updated early");
  done_set_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(ack_q[0]) || $rose(err_q[0]) |-> endpointReceiveDoneBit[0])
    else $error("done bit missing");
  reset_zero_a: assert property (@(posedge clock)
    !nrst |=> sfrRdata == `URS_RESET_STATUS) else $error("reset value");

  // ==========================================================
  // named steps of a receive transaction
  sequence seqNonIsoEnd;
    rxDone && rxValidToken && !rxIso;
  endsequence

  sequence seqIsoEnd;
    rxDone && rxValidToken && rxIso;
  endsequence

  sequence seqNoVoid;
    !fifoLocked && !receiveStallControl[rxEp];
  endsequence

  sequence seqCleanData;
    !crcFail && !stuffError && !fifoOverUnder;
  endsequence

  sequence seqBadData;
    crcFail || stuffError || fifoOverUnder;
  endsequence

  // ==========================================================
  // outcome checks, non-iso path
  ack_on_clean_a: assert property (@(posedge clock) disable iff (!nrst)
    seqNonIsoEnd ##0 seqNoVoid ##0 seqCleanData
    |=> rxHandshakeAck && ack_q[$past(rxEp)]) else $error("ack missing");
  err_on_fault_a: assert property (@(posedge clock) disable iff (!nrst)
    seqNonIsoEnd ##0 seqNoVoid ##0 seqBadData
    |=> err_q[$past(rxEp)] && !ack_q[$past(rxEp)])
    else $error("error flag missing");
  void_locked_a: assert property (@(posedge clock) disable iff (!nrst)
    seqNonIsoEnd ##0 fifoLocked
    |=> void_q[$past(rxEp)] && !rxHandshakeAck) else $error("locked not void");
  hs_source_a: assert property (@(posedge clock) disable iff (!nrst)
    rxHandshakeAck |-> $past(rxDone && rxValidToken)) else $error("stray handshake");

  // ==========================================================
  // iso deferral on endpoint 0
  iso_pend_set_a: assert property (@(posedge clock) disable iff (!nrst)
    seqIsoEnd ##0 (rxEp == '0) |=> pend_q[0]) else $error("iso not held");
  iso_sof_apply_a: assert property (@(posedge clock) disable iff (!nrst)
    pend_q[0] && sofSeen && !(rxDone && rxValidToken && rxEp == '0)
    |=> (ack_q[0] == ($past(pendRes_q[0]) == urs_pkg::URS_RES_ACK))
        && (err_q[0] == ($past(pendRes_q[0]) == urs_pkg::URS_RES_ERR)))
    else $error("iso result not applied");

  // ==========================================================
  // done bit and toggle on endpoint 0, read of other addresses
  done_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    doneClear[0] && !rxDone && !sofSeen |=> !endpointReceiveDoneBit[0])
    else $error("done not cleared");
  toggle_ovw_a: assert property (@(posedge clock) disable iff (!nrst)
    wrStatus && epIndex == '0 && sfrWdata[`URS_BIT_TOGGLE_OVW]
    |=> toggle_q[0] == $past(sfrWdata[`URS_BIT_TOGGLE]))
    else $error("toggle not loaded");
  toggle_flip_a: assert property (@(posedge clock) disable iff (!nrst)
    seqNonIsoEnd ##0 seqNoVoid ##0 seqCleanData ##0 (rxEp == '0 && !wrStatus)
    |=> toggle_q[0] != $past(toggle_q[0])) else $error("toggle not flipped");
  read_other_a: assert property (@(posedge clock) disable iff (!nrst)
    sfrAddr != `URS_ADDR_RXSTATUS |=> sfrRdata == `URS_RESET_STATUS)
    else $error("read of other address");
endmodule : urs_receive_status

// ### urs_host_model.sv
`timescale 1ns/100ps
module urs_host_model (
  // bench control
  input wire logic clock,
  input wire logic go,
  input wire logic [4:0] kind,
  input wire logic [1:0] ep,
  input wire logic bad,
  // engine side
  output logic rxDone,
  output logic [1:0] rxEp,
  output logic rxIso,
  output logic rxIsSetup,
  output logic rxValidToken,
  output logic crcFail,
  output logic stuffError,
  output logic fifoOverUnder,
  output logic sofSeen
);
  // kind bits: crc, stuff, fifo, iso, frame start only
  // outside a pulse the causes show junk, never a kind idle value
  always_ff @(posedge clock) begin
    rxDone <= go & ~kind[4];
    sofSeen <= go & kind[4];
    rxValidToken <= ~(go & bad);
    rxIsSetup <= go & ep == 2'h0;
    rxIso <= go & kind[3];
    rxEp <= go ? ep : ~ep;
    {fifoOverUnder, stuffError, crcFail} <= go ? kind[2:0] : 3'h7;
  end
endmodule : urs_host_model

// ### tb.sv
`timescale 1ns/100ps
`include "urs_consts.svh"
module tb;
  logic clock = 1'h0, nrst = 1'h0, go = 1'h0, fifoLocked = 1'h0;
  logic hsSeen, rxDone, rxIso, rxIsSetup, rxValidToken, crcFail, stuffError;
  logic fifoOverUnder, sofSeen, rxHandshakeAck;
  logic [1:0] ep = 2'h0, epIndex = 2'h0, rxEp;
  logic [4:0] kind = 5'h00;
  logic sfrWr = 1'h0, badTok = 1'h0;
  logic [7:0] sfrWdata = 8'h00;
  logic [3:0] stall = 4'h0, doneClear = 4'h0, done;
  logic [7:0] sfrAddr = 8'h00, sfrRdata;
  int err_total = 0, cmp_count = 0;
  always #2 clock = ~clock;
  urs_receive_status #(.NumEp(4), .IdxW(2)) urs_receive_status_inst (
    .clock(clock), .nrst(nrst), .rxDone(rxDone), .rxEp(rxEp), .rxIso(rxIso),
    .rxIsSetup(rxIsSetup), .rxValidToken(rxValidToken), .crcFail(crcFail),
    .stuffError(stuffError), .fifoOverUnder(fifoOverUnder), .fifoLocked(fifoLocked),
    .receiveStallControl(stall), .sofSeen(sofSeen), .rxToggleIn(1'h0),
    .epIndex(epIndex), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrWdata(sfrWdata),
    .doneClear(doneClear), .sfrRdata(sfrRdata), .rxHandshakeAck(rxHandshakeAck),
    .endpointReceiveDoneBit(done));
  urs_host_model urs_host_model_inst (.clock(clock), .go(go), .kind(kind), .ep(ep), .bad(badTok),
    .rxDone(rxDone), .rxEp(rxEp), .rxIso(rxIso), .rxIsSetup(rxIsSetup),
    .rxValidToken(rxValidToken), .crcFail(crcFail), .stuffError(stuffError),
    .fifoOverUnder(fifoOverUnder), .sofSeen(sofSeen));
  // ==========
  // access tasks
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(logic [4:0] k, logic [1:0] e);
    @(posedge clock);
    go <= 1'h1;
    kind <= k;
    ep <= e;
    @(posedge clock);
    go <= 1'h0;
    @(posedge clock);
    #1 hsSeen = rxHandshakeAck;
  endtask : xfer
  task automatic rd(logic [1:0] e, logic [7:0] a, logic [7:0] exp);
    @(posedge clock);
    epIndex <= e;
    sfrAddr <= a;
    @(posedge clock);
    #1 chk("status", sfrRdata, exp);
  endtask : rd
  task automatic wr(logic [1:0] e, logic [7:0] d);
    @(posedge clock);
    epIndex <= e;
    sfrAddr <= `URS_ADDR_RXSTATUS;
    sfrWr <= 1'h1;
    sfrWdata <= d;
    @(posedge clock);
    sfrWr <= 1'h0;
  endtask : wr
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // ==========
  // tests
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'h1;
    for (int i = 0; i < 4; i++) rd(i[1:0], `URS_ADDR_RXSTATUS, 8'h00);
    rd(2'h1, 8'h10, 8'h00);
    $display("reset test done");
    xfer(5'h00, 2'h1);
    chk("hs", {7'h00, hsSeen}, 8'h01);
    chk("done", {4'h0, done}, 8'h02);
    rd(2'h1, `URS_ADDR_RXSTATUS, 8'h81);
    xfer(5'h00, 2'h2);
    for (int k = 1; k < 5; k = k * 2) begin
      xfer(k[4:0], 2'h2);
      chk("hs", {7'h00, hsSeen}, 8'h00);
      rd(2'h2, `URS_ADDR_RXSTATUS, 8'h82);
    end
    $display("ack and error test done");
    stall <= 4'h8;
    xfer(5'h00, 2'h3);
    chk("hs", {7'h00, hsSeen}, 8'h00);
    rd(2'h3, `URS_ADDR_RXSTATUS, 8'h04);
    stall <= 4'h0;
    fifoLocked <= 1'h1;
    xfer(5'h00, 2'h0);
    rd(2'h0, `URS_ADDR_RXSTATUS, 8'h04);
    fifoLocked <= 1'h0;
    $display("void test done");
    @(posedge clock);
    doneClear <= 4'h2;
    @(posedge clock);
    doneClear <= 4'h0;
    #1 chk("done", {7'h00, done[1]}, 8'h00);
    xfer(5'h09, 2'h1);
    rd(2'h1, `URS_ADDR_RXSTATUS, 8'h81);
    chk("done", {7'h00, done[1]}, 8'h00);
    xfer(5'h10, 2'h0);
    rd(2'h1, `URS_ADDR_RXSTATUS, 8'h82);
    chk("done", {7'h00, done[1]}, 8'h01);
    @(posedge clock);
    doneClear <= 4'h2;
    @(posedge clock);
    doneClear <= 4'h0;
    #1 chk("done", {7'h00, done[1]}, 8'h00);
    $display("iso and clear test done");
    badTok <= 1'h1;
    xfer(5'h00, 2'h1);
    chk("hs", {7'h00, hsSeen}, 8'h00);
    badTok <= 1'h0;
    rd(2'h1, `URS_ADDR_RXSTATUS, 8'h82);
    wr(2'h1, 8'h08);
    rd(2'h1, `URS_ADDR_RXSTATUS, 8'h02);
    $display("token and toggle test done");
    tally_and_finish();
  end
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end
endmodule : tb
